// ---- ssr_pkg.sv ----
package ssr_pkg;
   localparam int SSR_SW_W = 16;
   localparam int SSR_AW   = 32;
   // status word field positions
   localparam int SSR_TRACE_BIT  = 15;
   localparam int SSR_PRIV_BIT   = 13;
   localparam int SSR_MASTER_BIT = 12;
   localparam int SSR_MASK_HI    = 10;
   localparam int SSR_MASK_LO    = 8;
   localparam int SSR_CCB_W      = 8;
   // defined bits: 15,13,12,10..8,4..0
   localparam logic [15:0] SSR_SW_DEFINED = 16'hb71f;
   localparam logic [15:0] SSR_CCB_MASK   = 16'h001f;
   // privileged at reset, mask at highest level
   localparam logic [15:0] SSR_SW_RESET   = 16'h2700;
   localparam logic [31:0] SSR_ETB_MASK   = 32'hfff0_0000;
   localparam int SSR_ETB_LOW_BITS = 20;
   localparam logic [2:0] SSR_NMI_LEVEL   = 3'h7;
   localparam int SSR_VEC_SHIFT    = 2;

   typedef enum logic [2:0] {
      SSR_SEL_NONE  = 3'b000,
      SSR_SEL_SW    = 3'b001,
      SSR_SEL_ASP   = 3'b010,
      SSR_SEL_OSP   = 3'b011,
      SSR_SEL_ETB   = 3'b100,
      SSR_SEL_USP   = 3'b101
   } ssr_sel_e;

   typedef struct packed {
      logic        wr;
      ssr_sel_e    sel;
      logic [31:0] data;
   } ssr_acc_s;

   typedef struct packed {
      logic       take;
      logic       is_irq;
      logic [2:0] level;
      logic [7:0] vector;
   } ssr_exc_s;
endpackage

// ---- ssr_irq_gate.sv ----
`timescale 1ns/10ps
module ssr_irq_gate
   import ssr_pkg::*;
(
   // request and mask
   input  wire logic [2:0] req_level_i,
   input  wire logic [2:0] mask_i,
   // result
   output logic            pass_o
);
   always_comb begin
      // level 0 means no request
      pass_o = (req_level_i == SSR_NMI_LEVEL) || (req_level_i > mask_i);
   end
endmodule

// ---- ssr_supervisor_regs.sv ----
`timescale 1ns/10ps
// Functional notes
// - status word fully accessible when privileged; user sees only low byte.
// - trace bit set requests a trace exception after each completed instruction.
// - status bit 13 is privilege: one supervisor, zero user.
// - master bit cleared on interrupt; set only by return or status move.
// - mask bits 10..8 block requests at or below mask level.
// - level 7 edge request is never masked.
// - two 32-bit stack pointers, active by privilege, alternate holds other.
// - debug port reads and writes both pointers directly; debugger maps them.
// - dual stacks only while enable bit set; enable resets to zero.
// - privileged moves copy address register to/from user stack pointer.
// - low 20 bits of table base not implemented, read as zero.
// - vector address is table base plus displacement.
// - displacement is four times the vector number.
// - exception saves status, sets privilege, clears trace; irq clears master, loads mask.
module ssr_supervisor_regs
   import ssr_pkg::*;
(
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // pipeline register access
   input  wire ssr_acc_s    pipe_acc_i,
   input  wire logic        rte_i,
   output logic [31:0]      pipe_rdata_o,
   output logic             priv_fault_o,
   // debug port access
   input  wire ssr_acc_s    dbg_acc_i,
   output logic [31:0]      dbg_rdata_o,
   // cache control enable bit
   input  wire logic        dual_stack_enable_bit_i,
   // instruction completion and exceptions
   input  wire logic        insn_done_i,
   input  wire ssr_exc_s    exc_i,
   input  wire logic [2:0]  irq_level_i,
   // status outputs
   output logic             trace_req_o,
   output logic             irq_pass_o,
   output logic [15:0]      status_word_o,
   output logic [15:0]      saved_status_o,
   output logic [31:0]      stack_pointer_o,
   output logic [31:0]      vector_addr_o
);
   logic [15:0] sw_q, sw_d, saved_q, saved_d;
   logic [31:0] asp_q, asp_d, osp_q, osp_d, etb_q, etb_d, vaddr_q, vaddr_d;
   logic [31:0] prdata_q, prdata_d, drdata_q, drdata_d;
   logic        trace_q, trace_d, fault_q, fault_d;
   logic        priv, dual, pipe_priv_ok;

   // read mux used by both ports
   function automatic logic [31:0] rd_sel(input ssr_sel_e s, input logic [15:0] sw,
                                          input logic [31:0] a, input logic [31:0] o,
                                          input logic [31:0] e);
      case (s)
         SSR_SEL_SW:  rd_sel = {16'h0000, sw};
         SSR_SEL_ASP: rd_sel = a;
         SSR_SEL_OSP: rd_sel = o;
         SSR_SEL_ETB: rd_sel = e & SSR_ETB_MASK;
         default:     rd_sel = 32'h0000_0000;
      endcase
   endfunction

   assign priv = sw_q[SSR_PRIV_BIT];
   assign dual = dual_stack_enable_bit_i;

   ssr_irq_gate u_gate (
      .req_level_i (irq_level_i),
      .mask_i      (sw_q[SSR_MASK_HI:SSR_MASK_LO]),
      .pass_o      (irq_pass_o)
   );

   always_comb begin
      logic [15:0] nsw;
      logic [31:0] wv;
      logic [31:0] sp_tmp;
      nsw      = sw_q;
      wv       = 32'h0000_0000;
      sp_tmp   = 32'h0000_0000;
      sw_d     = sw_q;
      saved_d  = saved_q;
      asp_d    = asp_q;
      osp_d    = osp_q;
      etb_d    = etb_q;
      vaddr_d  = vaddr_q;
      fault_d  = 1'b0;
      trace_d  = insn_done_i & sw_q[SSR_TRACE_BIT];
      pipe_priv_ok = priv;
      prdata_d = prdata_q;
      drdata_d = drdata_q;

      // pipeline access: user mode limited to the flags byte and the active stack pointer
      if (pipe_acc_i.sel != SSR_SEL_NONE) begin
         if (!pipe_priv_ok && pipe_acc_i.sel != SSR_SEL_SW && pipe_acc_i.sel != SSR_SEL_ASP) begin
            fault_d = 1'b1;
         end else if (pipe_acc_i.sel == SSR_SEL_USP) begin
            if (!dual || !priv) begin
               fault_d = 1'b1;
            end else if (pipe_acc_i.wr) begin
               osp_d = pipe_acc_i.data;
            end else begin
               prdata_d = osp_q;
            end
         end else if (pipe_acc_i.wr) begin
            case (pipe_acc_i.sel)
               SSR_SEL_SW: begin
                  if (priv) begin
                     sw_d = pipe_acc_i.data[15:0] & SSR_SW_DEFINED;
                  end else begin
                     sw_d = (sw_q & ~SSR_CCB_MASK) | (pipe_acc_i.data[15:0] & SSR_CCB_MASK);
                  end
               end
               SSR_SEL_ASP: asp_d = pipe_acc_i.data;
               SSR_SEL_OSP: osp_d = pipe_acc_i.data;
               SSR_SEL_ETB: etb_d = pipe_acc_i.data & SSR_ETB_MASK;
               default: ;
            endcase
         end else if (!priv && pipe_acc_i.sel == SSR_SEL_SW) begin
            prdata_d = {24'h00_0000, sw_q[SSR_CCB_W-1:0]};
         end else begin
            prdata_d = rd_sel(pipe_acc_i.sel, sw_q, asp_q, osp_q, etb_q);
         end
      end

      // return from exception restores the stacked word, master included
      if (rte_i && priv) begin
         sw_d = pipe_acc_i.data[15:0] & SSR_SW_DEFINED;
      end

      // debug port: raw access to both pointers
      if (dbg_acc_i.sel != SSR_SEL_NONE) begin
         if (dbg_acc_i.wr) begin
            case (dbg_acc_i.sel)
               SSR_SEL_SW:  sw_d  = dbg_acc_i.data[15:0] & SSR_SW_DEFINED;
               SSR_SEL_ASP: asp_d = dbg_acc_i.data;
               SSR_SEL_OSP: osp_d = dbg_acc_i.data;
               SSR_SEL_ETB: etb_d = dbg_acc_i.data & SSR_ETB_MASK;
               default: ;
            endcase
         end else begin
            drdata_d = rd_sel(dbg_acc_i.sel, sw_q, asp_q, osp_q, etb_q);
         end
      end

      // exception entry has priority over software writes
      if (exc_i.take) begin
         saved_d = sw_q;
         nsw = sw_q;
         nsw[SSR_PRIV_BIT]  = 1'b1;
         nsw[SSR_TRACE_BIT] = 1'b0;
         if (exc_i.is_irq) begin
            nsw[SSR_MASTER_BIT] = 1'b0;
            nsw[SSR_MASK_HI:SSR_MASK_LO] = exc_i.level;
         end
         sw_d = nsw;
         wv = 32'(exc_i.vector) << SSR_VEC_SHIFT;
         vaddr_d = (etb_q & SSR_ETB_MASK) + wv;
      end

      // privilege flip swaps physical registers so later refs see the new stack
      if (dual && (sw_d[SSR_PRIV_BIT] != sw_q[SSR_PRIV_BIT])) begin
         // keep the old active value aside, otherwise both sides end up equal
         sp_tmp = asp_d;
         asp_d  = osp_d;
         osp_d  = sp_tmp;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sw_q     <= SSR_SW_RESET;
         saved_q  <= 16'h0000;
         asp_q    <= 32'h0000_0000;
         osp_q    <= 32'h0000_0000;
         etb_q    <= 32'h0000_0000;
         vaddr_q  <= 32'h0000_0000;
         prdata_q <= 32'h0000_0000;
         drdata_q <= 32'h0000_0000;
         trace_q  <= 1'b0;
         fault_q  <= 1'b0;
      end else begin
         sw_q     <= sw_d;
         saved_q  <= saved_d;
         asp_q    <= asp_d;
         osp_q    <= osp_d;
         etb_q    <= etb_d;
         vaddr_q  <= vaddr_d;
         prdata_q <= prdata_d;
         drdata_q <= drdata_d;
         trace_q  <= trace_d;
         fault_q  <= fault_d;
      end
   end

   assign pipe_rdata_o    = prdata_q;
   assign dbg_rdata_o     = drdata_q;
   assign priv_fault_o    = fault_q;
   assign trace_req_o     = trace_q;
   assign status_word_o   = sw_q;
   assign saved_status_o  = saved_q;
   assign stack_pointer_o = asp_q;
   assign vector_addr_o   = vaddr_q;

   property p_trace;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (insn_done_i && sw_q[SSR_TRACE_BIT]) |=> trace_req_o;
   endproperty
   a_trace: assert property (p_trace) else $error("trace request missing");

   property p_exc_priv;
      @(posedge mclk_i) disable iff (!rst_n_i)
      exc_i.take |=> (sw_q[SSR_PRIV_BIT] && !sw_q[SSR_TRACE_BIT]);
   endproperty
   a_exc_priv: assert property (p_exc_priv) else $error("exception entry bits wrong");

   property p_irq_master;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (exc_i.take && exc_i.is_irq) |=> (!sw_q[SSR_MASTER_BIT]
         && sw_q[SSR_MASK_HI:SSR_MASK_LO] == $past(exc_i.level));
   endproperty
   a_irq_master: assert property (p_irq_master) else $error("irq entry wrong");

   property p_saved;
      @(posedge mclk_i) disable iff (!rst_n_i)
      exc_i.take |=> saved_status_o == $past(sw_q);
   endproperty
   a_saved: assert property (p_saved) else $error("status not saved");

   property p_vaddr;
      @(posedge mclk_i) disable iff (!rst_n_i)
      exc_i.take |=> vector_addr_o == (($past(etb_q) & SSR_ETB_MASK)
         + {22'h00_0000, $past(exc_i.vector), 2'b00});
   endproperty
   a_vaddr: assert property (p_vaddr) else $error("vector address wrong");

   property p_etb_low;
      @(posedge mclk_i) disable iff (!rst_n_i)
      etb_q[SSR_ETB_LOW_BITS-1:0] == 20'h00000;
   endproperty
   a_etb_low: assert property (p_etb_low) else $error("base low bits set");

   property p_user_sw;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (!priv && pipe_acc_i.sel == SSR_SEL_SW && pipe_acc_i.wr && !exc_i.take
         && dbg_acc_i.sel == SSR_SEL_NONE && !rte_i)
         |=> sw_q[15:8] == $past(sw_q[15:8]);
   endproperty
   a_user_sw: assert property (p_user_sw) else $error("user wrote upper status");

   property p_swap;
      @(posedge mclk_i) disable iff (!rst_n_i)
      ($past(dual) && $changed(sw_q[SSR_PRIV_BIT]) && $past(dbg_acc_i.sel) == SSR_SEL_NONE
         && $past(pipe_acc_i.sel) == SSR_SEL_NONE)
         |-> asp_q == $past(osp_q) && osp_q == $past(asp_q);
   endproperty
   a_swap: assert property (p_swap) else $error("stack swap missing");

   property p_nmi;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (irq_level_i == SSR_NMI_LEVEL) |-> irq_pass_o;
   endproperty
   a_nmi: assert property (p_nmi) else $error("level 7 masked");

   property p_mask;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (irq_level_i != SSR_NMI_LEVEL && irq_level_i <= sw_q[SSR_MASK_HI:SSR_MASK_LO])
         |-> !irq_pass_o;
   endproperty
   a_mask: assert property (p_mask) else $error("masked level passed");
endmodule

// ---- ssr_far_model.sv ----
`timescale 1ns/10ps
module ssr_far_model
   import ssr_pkg::*;
(
   // clock
   input  wire logic mclk_i,
   // requests towards the block
   output ssr_acc_s  pipe_acc_o,
   output ssr_acc_s  dbg_acc_o,
   output logic      rte_o
);
   initial begin
      pipe_acc_o = '0;
      dbg_acc_o  = '0;
      rte_o      = 1'b0;
   end

   // return from exception: the popped status rides on the data field with no select
   task automatic pop_status(input logic [15:0] sw);
      @(posedge mclk_i);
      pipe_acc_o <= '{1'b0, SSR_SEL_NONE, {16'h0000, sw}};
      rte_o      <= 1'b1;
      @(posedge mclk_i);
      pipe_acc_o <= '0;
      rte_o      <= 1'b0;
   endtask

   // one access, held only for the edge that takes it; raw lets a test write reserved bits
   task automatic issue(input logic dbg, input logic wr, input ssr_sel_e sel,
                        input logic [31:0] data, input logic raw);
      ssr_acc_s a;
      a = '{wr, sel, data};
      if (sel == SSR_SEL_SW && !raw)
         a.data = data & 32'h0000b71f;
      @(posedge mclk_i);
      if (dbg)
         dbg_acc_o <= a;
      else
         pipe_acc_o <= a;
      @(posedge mclk_i);
      dbg_acc_o  <= '0;
      pipe_acc_o <= '0;
   endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
   import ssr_pkg::*;
   typedef struct packed {logic [2:0] mask; logic [2:0] lvl; logic pass;} ssr_row_s;
   logic        mclk_i, rst_n_i, dual, done, fault, trace, pass, return_from_exception_op;
   ssr_acc_s    pipe_acc, dbg_acc;
   ssr_exc_s    exc;
   logic [2:0]  irq_lvl;
   logic [15:0] sw, ssw;
   logic [31:0] prd, drd, sp, va;
   int          fail_count = 0;
   int          n_compared = 0;
   int          cycles     = 0;
   ssr_row_s    rows [6] = '{'{3'h3, 3'h3, 1'b0}, '{3'h3, 3'h4, 1'b1}, '{3'h7, 3'h7, 1'b1},
                             '{3'h7, 3'h6, 1'b0}, '{3'h0, 3'h1, 1'b1}, '{3'h0, 3'h0, 1'b0}};

   ssr_far_model i_ssr_far_model (.mclk_i(mclk_i), .pipe_acc_o(pipe_acc), .dbg_acc_o(dbg_acc),
                                  .rte_o(return_from_exception_op));
   ssr_supervisor_regs i_ssr_supervisor_regs (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .pipe_acc_i(pipe_acc), .rte_i(return_from_exception_op),
      .pipe_rdata_o(prd), .priv_fault_o(fault), .dbg_acc_i(dbg_acc), .dbg_rdata_o(drd),
      .dual_stack_enable_bit_i(dual), .insn_done_i(done), .exc_i(exc),
      .irq_level_i(irq_lvl), .trace_req_o(trace), .irq_pass_o(pass), .status_word_o(sw),
      .saved_status_o(ssw), .stack_pointer_o(sp), .vector_addr_o(va));

   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic ends(input string name);
      $display("test %s done", name);
   endtask

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic pulse_exc(input ssr_exc_s e);
      @(posedge mclk_i);
      exc <= e;
      @(posedge mclk_i);
      exc <= '0;
      #1;
   endtask

   // generous ceiling: the sequence needs well under 200 cycles
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         report_and_stop();
      end
   end

   initial begin
      rst_n_i = 1'b0;
      dual    = 1'b0;
      done    = 1'b0;
      exc     = '0;
      irq_lvl = 3'h0;
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      #1;
      chk(sw, 16'h2700);
      chk(sp, 32'h0);
      ends("reset");
      foreach (rows[k]) begin
         i_ssr_far_model.issue(0, 1, SSR_SEL_SW, {18'h0, 1'b1, 2'b00, rows[k].mask, 8'h00}, 0);
         @(posedge mclk_i);
         irq_lvl <= rows[k].lvl;
         @(posedge mclk_i);
         #1;
         chk(pass, rows[k].pass);
         chk(sw, {2'b00, 1'b1, 2'b00, rows[k].mask, 8'h00});
      end
      ends("mask table");
      // reserved bits written on purpose must read back as zero
      i_ssr_far_model.issue(0, 1, SSR_SEL_SW, 32'h0000ffff, 1);
      #1;
      chk(sw, 16'hb71f);
      @(posedge mclk_i);
      done <= 1'b1;
      @(posedge mclk_i);
      done <= 1'b0;
      #1;
      chk(trace, 1'b1);
      ends("trace");
      i_ssr_far_model.issue(1, 1, SSR_SEL_ETB, 32'h12345678, 0);
      i_ssr_far_model.issue(1, 0, SSR_SEL_ETB, 32'h0, 0);
      #1;
      chk(drd, 32'h12300000);
      pulse_exc('{1'b1, 1'b0, 3'h0, 8'h03});
      chk(va, 32'h1230000c);
      chk(sw, 16'h371f);
      chk(ssw, 16'hb71f);
      pulse_exc('{1'b1, 1'b1, 3'h5, 8'h40});
      chk(va, 32'h12300100);
      chk(sw, 16'h251f);
      ends("exceptions");
      @(posedge mclk_i);
      dual <= 1'b1;
      i_ssr_far_model.issue(0, 1, SSR_SEL_ASP, 32'haaaa0000, 0);
      i_ssr_far_model.issue(0, 1, SSR_SEL_OSP, 32'h55550000, 0);
      #1;
      chk(sp, 32'haaaa0000);
      i_ssr_far_model.issue(0, 0, SSR_SEL_USP, 32'h0, 0);
      #1;
      chk(prd, 32'h55550000);
      i_ssr_far_model.issue(0, 1, SSR_SEL_SW, 32'h0, 0);
      #1;
      chk(sw, 16'h0000);
      chk(sp, 32'h55550000);
      i_ssr_far_model.issue(0, 1, SSR_SEL_ETB, 32'h0, 0);
      #1;
      chk(fault, 1'b1);
      i_ssr_far_model.issue(0, 1, SSR_SEL_SW, 32'h0000ffff, 1);
      #1;
      chk(sw, 16'h001f);
      i_ssr_far_model.issue(0, 0, SSR_SEL_SW, 32'h0, 0);
      #1;
      chk(prd, 32'h0000001f);
      i_ssr_far_model.issue(1, 0, SSR_SEL_OSP, 32'h0, 0);
      #1;
      chk(drd, 32'haaaa0000);
      ends("stacks and user mode");
      // exception from user mode swaps the stacks with no access in flight
      pulse_exc('{1'b1, 1'b0, 3'h0, 8'h02});
      chk(sp, 32'haaaa0000);
      chk(sw, 16'h201f);
      chk(ssw, 16'h001f);
      chk(va, 32'h12300008);
      i_ssr_far_model.pop_status(16'h101f);
      #1;
      chk(sw, 16'h101f);
      chk(sp, 32'h55550000);
      ends("return from exception");
      // let the swap checks see the last privilege change
      repeat (2) @(posedge mclk_i);
      report_and_stop();
   end
endmodule
